//--- rtl/btw_trace.v
// branch and window trace capture with nibble-wide trace output port
`timescale 1ns/1ps
`include "btw_defines.vh"

// Function
// - branch trace records source and destination
// - per-class enables for branch capture
// - realtime mode never stalls, may drop
// - non-realtime mode stalls until output drains
// - continue mode overwrites oldest buffer entries
// - stop mode halts capture once buffer full
// - two window channels with own ranges
// - disabled window channel records nothing
// - direction filter: read, write or both
// - processor bus captures cpu cycles, hits included
// - system bus captures cpu/dma, no hits
// - system bus addresses keep low 28 bits
// - internal mode keeps last eight branches
// - branch and window addresses compressed against previous one of same stream; software pc always sent whole
// - software trace records pc and register
module btw_trace (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // mode controls
  input wire internal_mode,
  input wire realtime_mode,
  input wire trace_continue,
  input wire trace_restart,
  // branch events
  input wire br_valid,
  input wire [1:0] br_class,
  input wire [31:0] br_src,
  input wire [31:0] br_dst,
  input wire br_en_normal,
  input wire br_en_sub,
  input wire br_en_exc,
  // software trace events
  input wire sw_trace_en,
  input wire sw_valid,
  input wire [31:0] sw_pc,
  input wire [31:0] sw_reg,
  // processor bus
  input wire proc_valid,
  input wire [31:0] proc_addr,
  input wire proc_write,
  // x and y memory buses
  input wire x_valid,
  input wire [31:0] x_addr,
  input wire x_write,
  input wire y_valid,
  input wire [31:0] y_addr,
  input wire y_write,
  // internal system bus
  input wire sys_valid,
  input wire [31:0] sys_addr,
  input wire sys_write,
  input wire sys_cache_hit,
  // window channel a
  input wire win_a_en,
  input wire [1:0] win_a_dir,
  input wire [1:0] win_a_bus,
  input wire [31:0] win_a_start,
  input wire [31:0] win_a_end,
  // window channel b
  input wire win_b_en,
  input wire [1:0] win_b_dir,
  input wire [1:0] win_b_bus,
  input wire [31:0] win_b_start,
  input wire [31:0] win_b_end,
  // internal history read
  input wire [2:0] hist_sel,
  output reg [31:0] hist_src,
  output reg [31:0] hist_dst,
  // trace output port
  input wire trace_port_clock,
  output reg [3:0] trace_port_data,
  output reg trace_port_sync,
  output reg trace_port_valid,
  // status
  output reg cpu_stall,
  output reg trace_stopped,
  output reg trace_lost
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_SIZE = 5'h02;
  localparam [4:0] S_A = 5'h04;
  localparam [4:0] S_B = 5'h08;
  localparam [4:0] S_SPARE = 5'h10;

  function dir_ok;
    input [1:0] dir;
    input wr;
    begin
      dir_ok = wr ? dir[1] : dir[0];
    end
  endfunction

  // size of the changed low part
  function [1:0] size_code;
    input [31:0] a;
    input [31:0] p;
    begin
      if (a[31:4] == p[31:4]) begin
        size_code = `BTW_SIZE_4;
      end else if (a[31:8] == p[31:8]) begin
        size_code = `BTW_SIZE_8;
      end else if (a[31:16] == p[31:16]) begin
        size_code = `BTW_SIZE_16;
      end else begin
        size_code = `BTW_SIZE_32;
      end
    end
  endfunction

  function [3:0] nib_count;
    input [1:0] sz;
    begin
      case (sz)
        `BTW_SIZE_4: nib_count = 4'h1;
        `BTW_SIZE_8: nib_count = 4'h2;
        `BTW_SIZE_16: nib_count = 4'h4;
        default: nib_count = 4'h8;
      endcase
    end
  endfunction

  // window channel decode
  wire [1:0] ch_en;
  wire [3:0] ch_dir;
  wire [3:0] ch_bus;
  wire [63:0] ch_start;
  wire [63:0] ch_end;
  wire [1:0] hit;
  wire [1:0] hit_wr;
  wire [1:0] hit_sys;
  wire [63:0] hit_addr;

  assign ch_en = {win_b_en, win_a_en};
  assign ch_dir = {win_b_dir, win_a_dir};
  assign ch_bus = {win_b_bus, win_a_bus};
  assign ch_start = {win_b_start, win_a_start};
  assign ch_end = {win_b_end, win_a_end};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_win
      reg v;
      reg wr;
      reg [31:0] ad;
      reg is_sys;
      wire [31:0] lo;
      wire [31:0] hi;
      always @* begin
        is_sys = 1'b0;
        case (ch_bus[2*g+1:2*g])
          `BTW_BUS_PROC: begin
            v = proc_valid;
            wr = proc_write;
            ad = proc_addr;
          end
          `BTW_BUS_X: begin
            v = x_valid;
            wr = x_write;
            ad = x_addr;
          end
          `BTW_BUS_Y: begin
            v = y_valid;
            wr = y_write;
            ad = y_addr;
          end
          default: begin
            // cpu or dma, never cache hits
            v = sys_valid && !sys_cache_hit;
            wr = sys_write;
            ad = {4'h0, sys_addr[`BTW_SYS_ADDR_W-1:0]};
            is_sys = 1'b1;
          end
        endcase
      end
      // range bounds also lose the unknown bits on the system bus
      assign lo = is_sys ? {4'h0, ch_start[32*g+27:32*g]} :
                           ch_start[32*g+31:32*g];
      assign hi = is_sys ? {4'h0, ch_end[32*g+27:32*g]} :
                           ch_end[32*g+31:32*g];
      assign hit[g] = ch_en[g] && v && dir_ok(ch_dir[2*g+1:2*g], wr) &&
                      (ad >= lo) && (ad <= hi);
      assign hit_wr[g] = wr;
      assign hit_sys[g] = is_sys;
      assign hit_addr[32*g+31:32*g] = ad;
    end
  endgenerate

  // candidate entry selection
  reg br_take;
  reg cand_valid;
  reg multi;
  reg [`BTW_WORD_W-1:0] cand_word;

  always @* begin
    case (br_class)
      `BTW_CLS_NORM: br_take = br_valid && br_en_normal;
      `BTW_CLS_SUB: br_take = br_valid && br_en_sub;
      `BTW_CLS_EXC: br_take = br_valid && br_en_exc;
      default: br_take = 1'b0;
    endcase
    cand_valid = 1'b1;
    multi = 1'b0;
    if (br_take) begin
      cand_word = {1'b0, br_class, br_src, br_dst};
      multi = (sw_valid && sw_trace_en) || (|hit);
    end else if (sw_valid && sw_trace_en) begin
      cand_word = {`BTW_KIND_SW, sw_pc, sw_reg};
      multi = |hit;
    end else if (hit[0]) begin
      cand_word = {`BTW_KIND_WIN, hit_addr[31:0], 29'h0,
                   hit_sys[0], hit_wr[0], 1'b0};
      multi = hit[1];
    end else if (hit[1]) begin
      cand_word = {`BTW_KIND_WIN, hit_addr[63:32], 29'h0,
                   hit_sys[1], hit_wr[1], 1'b1};
    end else begin
      cand_valid = 1'b0;
      cand_word = {`BTW_WORD_W{1'b0}};
    end
  end

  // trace buffer
  wire fifo_out_valid;
  wire [`BTW_WORD_W-1:0] fifo_out_data;
  wire fifo_full;
  wire fifo_empty;
  wire fifo_out_ready;
  reg push_valid;
  reg [`BTW_WORD_W-1:0] push_word;
  reg discard;
  reg set_lost;
  reg pend_valid;
  reg [`BTW_WORD_W-1:0] pend_word;
  reg next_pend_valid;
  reg [`BTW_WORD_W-1:0] next_pend_word;
  reg [4:0] ser_state;
  reg tpc_s1;
  reg tpc_s2;
  reg tpc_d;
  wire tick;
  wire ser_load;
  wire busy;
  wire capturing;

  assign tick = tpc_s2 && !tpc_d;
  assign ser_load = tick && (ser_state == S_IDLE) && fifo_out_valid;
  assign busy = (ser_state != S_IDLE) || !fifo_empty;
  assign capturing = !internal_mode && !trace_stopped;
  assign fifo_out_ready = ser_load || discard;

  always @* begin
    push_valid = 1'b0;
    push_word = cand_word;
    discard = 1'b0;
    set_lost = capturing && cand_valid && multi;
    next_pend_valid = 1'b0;
    next_pend_word = pend_word;
    if (capturing) begin
      if (pend_valid) begin
        next_pend_valid = 1'b1;
        // release the held entry once drained
        if (!busy) begin
          push_valid = 1'b1;
          push_word = pend_word;
          next_pend_valid = 1'b0;
        end
        if (cand_valid) begin
          set_lost = 1'b1;
        end
      end else if (cand_valid) begin
        if (!realtime_mode && busy) begin
          next_pend_valid = 1'b1;
          next_pend_word = cand_word;
        end else begin
          push_valid = 1'b1;
        end
      end
      if (push_valid && fifo_full) begin
        if (trace_continue) begin
          discard = 1'b1;
        end else begin
          push_valid = 1'b0;
          set_lost = 1'b1;
        end
      end
    end
  end

  btw_fifo #(
    .W(`BTW_WORD_W),
    .D(`BTW_FIFO_DEPTH),
    .AW(`BTW_FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // capture control state
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_valid <= 1'b0;
      pend_word <= {`BTW_WORD_W{1'b0}};
      cpu_stall <= 1'b0;
      trace_stopped <= 1'b0;
      trace_lost <= 1'b0;
    end else begin
      pend_valid <= next_pend_valid;
      pend_word <= next_pend_word;
      // stall while an entry is held
      cpu_stall <= next_pend_valid;
      // stop once full; full beats restart
      if (!internal_mode && !trace_continue && fifo_full) begin
        trace_stopped <= 1'b1;
      end else if (trace_restart) begin
        trace_stopped <= 1'b0;
      end
      if (set_lost) begin
        trace_lost <= 1'b1;
      end else if (trace_restart) begin
        trace_lost <= 1'b0;
      end
    end
  end

  // last eight branches in internal mode
  reg [31:0] hsrc_mem [0:`BTW_HIST_DEPTH-1];
  reg [31:0] hdst_mem [0:`BTW_HIST_DEPTH-1];
  reg [`BTW_HIST_AW-1:0] hist_wptr;
  wire [`BTW_HIST_AW-1:0] hist_ridx;

  // zero selects the newest branch
  assign hist_ridx = hist_wptr - 3'h1 - hist_sel;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      hist_wptr <= 3'h0;
      hist_src <= 32'h0;
      hist_dst <= 32'h0;
    end else begin
      if (internal_mode && br_take) begin
        hist_wptr <= hist_wptr + 3'h1;
      end
      hist_src <= hsrc_mem[hist_ridx];
      hist_dst <= hdst_mem[hist_ridx];
    end
  end

  always @(posedge ref_clk) begin
    if (internal_mode && br_take) begin
      hsrc_mem[hist_wptr] <= br_src;
      hdst_mem[hist_wptr] <= br_dst;
    end
  end

  // trace port clock: two stages before the edge finder
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tpc_s1 <= 1'b0;
      tpc_s2 <= 1'b0;
      tpc_d <= 1'b0;
    end else begin
      tpc_s1 <= trace_port_clock;
      tpc_s2 <= tpc_s1;
      tpc_d <= tpc_s2;
    end
  end

  // serializer load decode
  wire [2:0] ld_kind;
  wire [31:0] ld_a;
  wire ld_br;
  wire [1:0] ld_size;
  reg [31:0] a_sh;
  reg [31:0] b_sh;
  reg [3:0] cnt;
  reg [3:0] nb;
  reg [1:0] cur_size;
  reg [31:0] prev_br;
  reg [31:0] prev_win;

  assign ld_kind = fifo_out_data[`BTW_KIND_HI:`BTW_KIND_LO];
  assign ld_a = fifo_out_data[`BTW_A_HI:`BTW_A_LO];
  assign ld_br = (ld_kind <= `BTW_KIND_BR_EXC);
  // compare with the previous address of the same stream
  assign ld_size = (ld_kind == `BTW_KIND_SW) ? `BTW_SIZE_32 :
                   ld_br ? size_code(ld_a, prev_br) :
                   size_code(ld_a, prev_win);

  // outputs change on a seen rising edge; sample on the next one
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      ser_state <= S_IDLE;
      a_sh <= 32'h0;
      b_sh <= 32'h0;
      cnt <= 4'h0;
      nb <= 4'h0;
      cur_size <= `BTW_SIZE_32;
      prev_br <= 32'h0;
      prev_win <= 32'h0;
      trace_port_data <= 4'h0;
      trace_port_sync <= 1'b0;
      trace_port_valid <= 1'b0;
    end else if (tick) begin
      case (ser_state)
        S_IDLE: begin
          if (fifo_out_valid) begin
            trace_port_data <= {1'b1, ld_kind};
            trace_port_sync <= 1'b1;
            trace_port_valid <= 1'b1;
            a_sh <= ld_a;
            b_sh <= fifo_out_data[`BTW_B_HI:`BTW_B_LO];
            cur_size <= ld_size;
            nb <= (ld_kind == `BTW_KIND_WIN) ? `BTW_NB_WIN : `BTW_NB_FULL;
            if (ld_br) begin
              prev_br <= ld_a;
            end else if (ld_kind == `BTW_KIND_WIN) begin
              prev_win <= ld_a;
            end
            ser_state <= S_SIZE;
          end else begin
            trace_port_data <= 4'h0;
            trace_port_sync <= 1'b0;
            trace_port_valid <= 1'b0;
          end
        end
        S_SIZE: begin
          trace_port_data <= {2'b00, cur_size};
          trace_port_sync <= 1'b0;
          cnt <= nib_count(cur_size);
          ser_state <= S_A;
        end
        S_A: begin
          trace_port_data <= a_sh[3:0];
          a_sh <= {4'h0, a_sh[31:4]};
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            cnt <= nb;
            ser_state <= S_B;
          end
        end
        S_B: begin
          trace_port_data <= b_sh[3:0];
          b_sh <= {4'h0, b_sh[31:4]};
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            ser_state <= S_IDLE;
          end
        end
        default: begin
          ser_state <= S_IDLE;
          trace_port_valid <= 1'b0;
          trace_port_sync <= 1'b0;
        end
      endcase
    end
  end
endmodule // btw_trace

//--- rtl/btw_defines.vh
// constants shared by the branch and window trace capture block
`ifndef BTW_DEFINES_VH
`define BTW_DEFINES_VH

// trace buffer shape
`define BTW_FIFO_DEPTH 4
`define BTW_FIFO_AW 2
`define BTW_WORD_W 67

// entry field positions
`define BTW_KIND_HI 66
`define BTW_KIND_LO 64
`define BTW_A_HI 63
`define BTW_A_LO 32
`define BTW_B_HI 31
`define BTW_B_LO 0

// entry kinds; branch kinds equal the branch class codes
`define BTW_KIND_BR_NORM 3'h0
`define BTW_KIND_BR_SUB 3'h1
`define BTW_KIND_BR_EXC 3'h2
`define BTW_KIND_WIN 3'h3
`define BTW_KIND_SW 3'h4

// branch classes
`define BTW_CLS_NORM 2'h0
`define BTW_CLS_SUB 2'h1
`define BTW_CLS_EXC 2'h2

// window bus selection
`define BTW_BUS_PROC 2'h0
`define BTW_BUS_X 2'h1
`define BTW_BUS_Y 2'h2
`define BTW_BUS_SYS 2'h3

// window direction filter
`define BTW_DIR_RD 2'h1
`define BTW_DIR_WR 2'h2
`define BTW_DIR_RW 2'h3

// compressed address size codes
`define BTW_SIZE_4 2'h0
`define BTW_SIZE_8 2'h1
`define BTW_SIZE_16 2'h2
`define BTW_SIZE_32 2'h3

// system bus carries only the low address bits
`define BTW_SYS_ADDR_W 28
`define BTW_HIST_DEPTH 8
`define BTW_HIST_AW 3

// nibble counts of the second field
`define BTW_NB_FULL 4'h8
`define BTW_NB_WIN 4'h1

`endif

//--- rtl/btw_fifo.v
// trace buffer: flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module btw_fifo #(
  parameter W = 67,
  parameter D = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  // status
  output wire full,
  output wire empty
);
  localparam [AW:0] FULL_CNT = D[AW:0];

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_push;
  wire do_pop;

  assign full = (count == FULL_CNT);
  assign empty = (count == {(AW+1){1'b0}});
  assign out_valid = !empty;
  // a pop in the same cycle frees the slot for the push
  assign in_ready = !full || out_ready;
  assign out_data = mem[rd_ptr];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // btw_fifo

//--- testbench/btw_trace_assertions.sv
// concurrent checks on the trace capture block ports
`timescale 1ns/1ps
module btw_trace_assertions (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // modes
  input wire realtime_mode,
  input wire trace_restart,
  // trace output and status
  input wire [3:0] trace_port_data,
  input wire trace_port_sync,
  input wire trace_port_valid,
  input wire cpu_stall,
  input wire trace_stopped,
  input wire trace_lost
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  reset_quiet_a: assert property (disable iff (1'b0)
    !rst_n |=> !trace_port_valid && !cpu_stall && !trace_stopped && !trace_lost)
    else $error("outputs not quiet after reset");
  stall_realtime_a: assert property (
    !cpu_stall && realtime_mode |=> !cpu_stall)
    else $error("stall raised in realtime mode");
  stall_cause_a: assert property (
    $rose(cpu_stall) |-> !$past(realtime_mode))
    else $error("stall without non-realtime mode");
  stall_bound_a: assert property (
    $rose(cpu_stall) |-> ##[1:1000] !cpu_stall)
    else $error("stall never released");
  stop_sticky_a: assert property (
    trace_stopped && !trace_restart |=> trace_stopped)
    else $error("stopped flag dropped without restart");
  lost_sticky_a: assert property (
    trace_lost && !trace_restart |=> trace_lost)
    else $error("lost flag dropped without restart");
  header_code_a: assert property (
    trace_port_sync |-> trace_port_valid && trace_port_data[3] &&
      trace_port_data[2:0] <= 3'h4)
    else $error("bad header nibble");
  size_nibble_a: assert property (
    $fell(trace_port_sync) && trace_port_valid |-> trace_port_data[3:2] == 2'h0)
    else $error("bad size nibble");
  header_hold_a: assert property (
    $rose(trace_port_sync) |-> trace_port_sync [*6])
    else $error("header nibble too short");
endmodule // btw_trace_assertions

//--- testbench/btw_emulator.sv
// trace port receiver standing in for the debug emulator
`timescale 1ns/1ps
module btw_emulator (
  // trace port
  output logic trace_port_clock,
  input wire [3:0] trace_port_data,
  input wire trace_port_sync,
  input wire trace_port_valid
);
  logic [68:0] rx_q[$];
  logic [2:0] kind;
  logic [1:0] size;
  logic [31:0] a, b;
  int n = 0, na, nb;
  initial begin
    trace_port_clock = 1'b0;
    forever #80 trace_port_clock = ~trace_port_clock;
  end
  // packet rebuild
  // sampled at the next rise, before the block reacts to it
  always @(posedge trace_port_clock) begin
    if (!trace_port_valid) begin
      n = 0;
    end else if (trace_port_sync) begin
      kind = trace_port_data[2:0];
      a = 32'h0;
      b = 32'h0;
      n = 1;
    end else if (n == 1) begin
      size = trace_port_data[1:0];
      na = 1 << size;
      nb = kind == 3'h3 ? 1 : 8;
      n = 2;
    end else if (n > 1) begin
      if (n < 2 + na) a[4 * (n - 2) +: 4] = trace_port_data;
      else b[4 * (n - 2 - na) +: 4] = trace_port_data;
      n++;
      if (n == 2 + na + nb) begin
        rx_q.push_back({size, kind, a, b});
        n = 0;
      end
    end
  end
endmodule // btw_emulator

//--- testbench/btw_trace_test.sv
// self-checking bench for the branch and window trace block
`timescale 1ns/1ps
`include "btw_defines.vh"
module btw_trace_test;
  logic ref_clk = 0, rst_n = 0, internal_mode = 0, realtime_mode = 0;
  logic trace_continue = 1, trace_restart = 0, br_valid = 0;
  logic br_en_normal = 1, br_en_sub = 1, br_en_exc = 1, sw_trace_en = 0;
  logic sw_valid = 0, proc_valid = 0, proc_write = 0, x_valid = 0;
  logic x_write = 0, y_valid = 0, y_write = 0, sys_valid = 0;
  logic sys_write = 0, sys_cache_hit = 0, win_a_en = 0, win_b_en = 0;
  logic [1:0] br_class = 0, win_a_dir = 0, win_a_bus = 0;
  logic [1:0] win_b_dir = 0, win_b_bus = 0, cb;
  logic [2:0] hist_sel = 0;
  logic [31:0] br_src = 0, br_dst = 0, sw_pc = 0, sw_reg = 0;
  logic [31:0] proc_addr = 0, x_addr = 0, y_addr = 0, sys_addr = 0;
  logic [31:0] win_a_start = 0, win_a_end = 0, win_b_start = 0;
  logic [31:0] win_b_end = 0, hist_src, hist_dst;
  logic [31:0] br_ref = 0, win_ref = 0, s, d, a, ad, m;
  logic [3:0] trace_port_data;
  logic trace_port_clock, trace_port_sync, trace_port_valid;
  logic cpu_stall, trace_stopped, trace_lost, wr, hc, ha, hb;
  int fails = 0, tests_run = 0;
  int lo[5] = '{0, 4, 8, 16, 32};

  btw_trace dut (.*);
  btw_emulator emu (.*);

  task automatic chk(logic [68:0] g, e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // expected packet, address trimmed to the compressed size
  function automatic logic [68:0] pkt(logic [2:0] k, logic [31:0] a, b, r);
    logic [1:0] z;
    z = a[31:4] == r[31:4] ? 0 : a[31:8] == r[31:8] ? 1 :
      a[31:16] == r[31:16] ? 2 : 3;
    if (k == `BTW_KIND_SW) z = 3;
    return {z, k, a & ~(32'hFFFFFFFF << (4 << z)), b};
  endfunction
  // system bus compares only the low 28 bits
  function automatic logic hit(logic e, logic [1:0] dr, bs,
    logic [31:0] st, nd);
    m = cb == `BTW_BUS_SYS ? 32'h0FFFFFFF : 32'hFFFFFFFF;
    return e && bs == cb && dr[wr] && !(cb == `BTW_BUS_SYS && hc) &&
      (ad & m) >= (st & m) && (ad & m) <= (nd & m);
  endfunction
  task automatic settle();
    int idle;
    idle = 0;
    for (int k = 0; k < 9000 && idle < 200; k++) begin
      @(posedge ref_clk);
      idle = trace_port_valid === 1'b0 ? idle + 1 : 0;
    end
    chk(idle, 200);
  endtask
  task automatic burst(int n, logic [1:0] c, logic [31:0] s, d);
    emu.rx_q.delete();
    br_valid <= 1;
    br_class <= c;
    br_src <= s;
    for (int i = 0; i < n; i++) begin
      br_dst <= d + i;
      @(posedge ref_clk);
    end
    br_valid <= 0;
  endtask
  task automatic acc(logic [1:0] b, logic w, h);
    emu.rx_q.delete();
    cb = b;
    wr = w;
    hc = h;
    if (b == `BTW_BUS_SYS) ad = ad ^ (($urandom & 32'hF) << 28);
    {proc_addr, x_addr, y_addr, sys_addr} <= {4{ad}};
    {proc_write, x_write, y_write, sys_write} <= {4{w}};
    sys_cache_hit <= h;
    {sys_valid, y_valid, x_valid, proc_valid} <= 4'h1 << b;
    @(posedge ref_clk);
    {sys_valid, y_valid, x_valid, proc_valid} <= 4'h0;
  endtask

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    close_out();
  end
  initial begin
    void'($urandom(32'h90678A02));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    for (int c = 0; c < 3; c++) begin
      {br_en_exc, br_en_sub, br_en_normal} <= 3'h7 & ~(3'h1 << c);
      burst(1, c, $urandom, $urandom);
      settle();
      chk(emu.rx_q.size(), 0);
      {br_en_exc, br_en_sub, br_en_normal} <= 3'h7;
      for (int j = 0; j < 4; j++) begin
        s = br_ref ^ ($urandom & 32'hF);
        if (j > 0) s = s ^ (32'h1 << (lo[j] + $urandom % (lo[j+1] - lo[j])));
        d = $urandom;
        burst(1, c, s, d);
        settle();
        chk(emu.rx_q[0], pkt(c, s, d, br_ref));
        br_ref = s;
      end
    end
    s = $urandom;
    d = $urandom;
    emu.rx_q.delete();
    sw_trace_en <= 1;
    sw_pc <= s;
    sw_reg <= d;
    sw_valid <= 1;
    @(posedge ref_clk);
    sw_valid <= 0;
    settle();
    chk(emu.rx_q[0], pkt(`BTW_KIND_SW, s, d, 0));
    for (int i = 0; i < 40; i++) begin
      a = $urandom;
      win_a_en <= $urandom;
      win_b_en <= $urandom;
      win_a_dir <= 1 + $urandom % 3;
      win_b_dir <= 1 + $urandom % 3;
      win_a_bus <= $urandom;
      win_b_bus <= $urandom;
      win_a_start <= a + $urandom % 8;
      win_a_end <= a + 8 + $urandom % 8;
      win_b_start <= a + $urandom % 16;
      win_b_end <= a + 16 + $urandom % 8;
      @(posedge ref_clk);
      // range edges first, then anywhere near the windows
      case (i % 5)
        0: ad = win_a_start;
        1: ad = win_a_end;
        2: ad = win_a_end + 1;
        3: ad = win_a_start - 1;
        default: ad = a + $urandom % 28;
      endcase
      acc($urandom, $urandom, $urandom % 4 == 0);
      ha = hit(win_a_en, win_a_dir, win_a_bus, win_a_start, win_a_end);
      hb = hit(win_b_en, win_b_dir, win_b_bus, win_b_start, win_b_end);
      settle();
      chk(emu.rx_q.size(), ha | hb);
      if (ha | hb) begin
        m = cb == `BTW_BUS_SYS ? {4'h0, ad[27:0]} : ad;
        chk(emu.rx_q[0], pkt(`BTW_KIND_WIN, m, {cb == 3, wr, !ha},
          win_ref));
        win_ref = m;
      end
    end
    // x traffic on channel a and y traffic on channel b in one cycle
    a = $urandom & 32'h7FFFFFF0;
    emu.rx_q.delete();
    {win_a_en, win_b_en, win_a_dir, win_b_dir} <= 6'h3F;
    {win_a_bus, win_b_bus} <= {`BTW_BUS_X, `BTW_BUS_Y};
    {win_a_start, win_b_start} <= {2{a}};
    {win_a_end, win_b_end} <= {2{a + 32'hF}};
    {x_addr, y_addr} <= {a + 32'h3, a + 32'h5};
    {x_write, y_write, x_valid, y_valid} <= 4'h3;
    @(posedge ref_clk);
    {x_valid, y_valid} <= 2'h0;
    settle();
    chk(emu.rx_q[0], pkt(`BTW_KIND_WIN, a + 32'h3, 0, win_ref));
    win_ref = a + 32'h3;
    // cache fill seen on the system bus by channel a
    win_a_bus <= `BTW_BUS_SYS;
    ad = a + 32'h7;
    acc(`BTW_BUS_SYS, 0, 0);
    settle();
    m = {4'h0, ad[27:0]};
    chk(emu.rx_q[0], pkt(`BTW_KIND_WIN, m, 32'h4, win_ref));
    win_ref = m;
    s = br_ref;
    d = $urandom;
    burst(2, 0, s, d);
    @(posedge ref_clk);
    #1 chk(cpu_stall, 1);
    settle();
    chk(emu.rx_q[1], pkt(0, s, d + 1, s));
    realtime_mode <= 1;
    trace_continue <= 0;
    burst(8, 0, s, d);
    @(posedge ref_clk);
    #1 chk({trace_stopped, trace_lost}, 2'h3);
    settle();
    chk(emu.rx_q[$][31:0] == d + 7, 0);
    burst(1, 0, s, d);
    settle();
    chk(emu.rx_q.size(), 0);
    trace_restart <= 1;
    @(posedge ref_clk);
    trace_restart <= 0;
    @(posedge ref_clk);
    #1 chk({trace_stopped, trace_lost}, 2'h0);
    @(posedge ref_clk);
    trace_continue <= 1;
    burst(8, 0, s, d);
    #1 chk(cpu_stall, 0);
    settle();
    chk(emu.rx_q.size() < 8, 1);
    chk(emu.rx_q[$][31:0], d + 7);
    internal_mode <= 1;
    burst(9, 0, s, d);
    settle();
    chk(emu.rx_q.size(), 0);
    for (int i = 0; i < 8; i++) begin
      hist_sel <= i;
      @(posedge ref_clk);
      #1 chk({hist_src, hist_dst}, {s, d + 8 - i});
      @(posedge ref_clk);
    end
    close_out();
  end
endmodule // btw_trace_test

bind btw_trace btw_trace_assertions chk_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .realtime_mode(realtime_mode),
  .trace_restart(trace_restart), .trace_port_data(trace_port_data),
  .trace_port_sync(trace_port_sync), .trace_port_valid(trace_port_valid),
  .cpu_stall(cpu_stall), .trace_stopped(trace_stopped),
  .trace_lost(trace_lost));
